// ==== inc/mse_pkg.sv ====
// shared constants for the motor start sequencer entry block
package mse_pkg;

  // apb register byte offsets
  localparam logic [7:0] MSE_CTRL_OFS = 8'h00;
  localparam logic [7:0] MSE_STAT_OFS = 8'h04;
  localparam logic [7:0] MSE_SPD_OFS = 8'h08;

  // control register field positions
  localparam int MSE_CTRL_EN_BIT = 0;
  localparam int MSE_CTRL_STH_LSB = 1;
  localparam int MSE_CTRL_RTH_LSB = 3;
  localparam int MSE_CTRL_RESTART_BIT = 5;

  // control reset values: detection off, lowest thresholds
  localparam logic MSE_CTRL_EN_RST = 1'b0;
  localparam logic [1:0] MSE_CTRL_STH_RST = 2'h0;
  localparam logic [1:0] MSE_CTRL_RTH_RST = 2'h0;

  // status register field positions
  localparam int MSE_STAT_STATE_LSB = 0;
  localparam int MSE_STAT_REV_BIT = 9;
  localparam int MSE_STAT_VALID_BIT = 10;

  // measured speed width and table of threshold levels
  localparam int MSE_SPD_W = 8;
  localparam logic [MSE_SPD_W-1:0] MSE_STILL_LVL0 = 8'h04;
  localparam logic [MSE_SPD_W-1:0] MSE_STILL_LVL1 = 8'h08;
  localparam logic [MSE_SPD_W-1:0] MSE_STILL_LVL2 = 8'h10;
  localparam logic [MSE_SPD_W-1:0] MSE_STILL_LVL3 = 8'h20;
  localparam logic [MSE_SPD_W-1:0] MSE_REV_LVL0 = 8'h08;
  localparam logic [MSE_SPD_W-1:0] MSE_REV_LVL1 = 8'h10;
  localparam logic [MSE_SPD_W-1:0] MSE_REV_LVL2 = 8'h20;
  localparam logic [MSE_SPD_W-1:0] MSE_REV_LVL3 = 8'h40;

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    MSE_POWER_ON = 9'h001,
    MSE_EN_CHECK = 9'h002,
    MSE_SPEED_DETECT = 9'h004,
    MSE_STILL_CHECK = 9'h008,
    MSE_DIR_CHECK = 9'h010,
    MSE_REV_CHECK = 9'h020,
    MSE_BRAKE_HANDOFF = 9'h040,
    MSE_CLOSED_HANDOFF = 9'h080,
    MSE_REVEN_HANDOFF = 9'h100
  } mse_state_e;

endpackage

// ==== inc/mse_cmp_if.sv ====
// carrier between the sequencer and a speed-versus-level comparator
`timescale 1ns/1ns
interface mse_cmp_if;
  import mse_pkg::*;
  logic [MSE_SPD_W-1:0] speed; // measured speed
  logic [MSE_SPD_W-1:0] level; // selected threshold level
  logic below; // speed strictly under level
  logic above; // speed strictly over level
  modport user (output speed, output level, input below, input above);
  modport cmp (input speed, input level, output below, output above);
endinterface

// ==== core/mse_cmp.sv ====
// speed comparator against one threshold level
`timescale 1ns/1ns
module mse_cmp
  import mse_pkg::*;
(
  mse_cmp_if.cmp cif
);

  // pure compare, no state; equality is neither below nor above
  always_comb begin
    cif.below = (cif.speed < cif.level);
    cif.above = (cif.speed > cif.level);
  end

endmodule

// ==== core/mse_seq.sv ====
// motor start sequencer entry: power-on, speed detection, routing, apb regs
//
// What this block does
// - power-on state at reset and low-power exit
// - enable set moves power-on into speed detection
// - detection disabled goes straight to brake decision
// - speed detection captures speed and direction first
// - speed below stationary level goes to brake
// - speed above stationary level goes to direction
// - direction decision classifies forward or reverse
// - forward spin enters feedback commutation directly
// - reverse spin goes to reverse speed check
// - fast reverse redetects, else reverse drive enable
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
module mse_seq
  import mse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power_exit,
  output logic detect_request,
  input wire logic detect_done,
  input wire logic [MSE_SPD_W-1:0] detect_speed,
  input wire logic detect_reverse,
  output logic brake_enable_decision,
  output logic feedback_commutation_state,
  output logic reverse_drive_enable
);

  // both compares see the captured speed, not the live measurement lines,
  // so a wandering input after detection cannot change the route
  // comparator carriers
  mse_cmp_if still_if (); // stationary threshold compare
  mse_cmp_if rev_if (); // reverse speed limit compare

  // control fields
  // all three fields reset to detection off and the lowest levels
  logic speed_detect_enable_reg; // detection switch
  logic speed_detect_enable_next;
  logic [1:0] stationary_speed_threshold_reg; // level select
  logic [1:0] stationary_speed_threshold_next;
  logic [1:0] reverse_speed_limit_reg; // level select
  logic [1:0] reverse_speed_limit_next;
  logic restart_reg; // one-cycle software restart
  logic restart_next;

  // apb answer
  // read data and error are both settled before the access edge
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;

  // sequencer state and captured measurement
  // valid_reg tells software that speed and direction are real
  mse_state_e state_reg;
  mse_state_e state_next;
  logic [MSE_SPD_W-1:0] speed_reg; // last measured speed
  logic [MSE_SPD_W-1:0] speed_next;
  logic reverse_reg; // last measured direction
  logic reverse_next;
  logic valid_reg; // a measurement has been taken
  logic valid_next;
  logic detect_request_reg;
  logic detect_request_next;

  // low-power exit pin synchroniser and edge detect
  // only the rising edge matters; a pin held high does not loop the start
  logic wake_s1_reg; // first stage, read only by second
  logic wake_s2_reg;
  logic wake_d_reg; // delayed copy for the edge
  logic wake_pulse;

  // bus decode helpers
  // setup_phase loads the answer, wr_take commits a write
  logic setup_phase;
  logic wr_take;
  logic addr_ok;

  // comparator instances
  mse_cmp u_still (
    .cif(still_if.cmp)
  );
  mse_cmp u_rev (
    .cif(rev_if.cmp)
  );

  // threshold code to level lookup; both compare the captured speed
  // level tables live in the package so the codes can be retuned
  always_comb begin
    still_if.speed = speed_reg;
    rev_if.speed = speed_reg;
    case (stationary_speed_threshold_reg)
      2'h0: still_if.level = MSE_STILL_LVL0;
      2'h1: still_if.level = MSE_STILL_LVL1;
      2'h2: still_if.level = MSE_STILL_LVL2;
      default: still_if.level = MSE_STILL_LVL3;
    endcase
    case (reverse_speed_limit_reg)
      2'h0: rev_if.level = MSE_REV_LVL0;
      2'h1: rev_if.level = MSE_REV_LVL1;
      2'h2: rev_if.level = MSE_REV_LVL2;
      default: rev_if.level = MSE_REV_LVL3;
    endcase
  end

  // wake synchroniser; pin is asynchronous to pclk
  // reset value matches the idle pin level, so no false wake after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_d_reg <= 1'b0;
    end else begin
      wake_s1_reg <= low_power_exit;
      wake_s2_reg <= wake_s1_reg;
      wake_d_reg <= wake_s2_reg;
    end
  end

  // rising edge of the synchronised level marks leaving standby or sleep
  assign wake_pulse = wake_s2_reg & ~wake_d_reg;

  // apb decode; zero wait states, answer prepared in the setup cycle
  // trade-off: read data is prepared one cycle early so the access phase
  // needs no wait state; the cost is a 32-bit holding register
  assign setup_phase = psel & ~penable;
  assign wr_take = psel & penable & pwrite & ~pslverr_reg;
  assign addr_ok = (paddr[7:0] == MSE_CTRL_OFS) || (paddr[7:0] == MSE_STAT_OFS) ||
                   (paddr[7:0] == MSE_SPD_OFS);

  // register file next values
  always_comb begin
    speed_detect_enable_next = speed_detect_enable_reg;
    stationary_speed_threshold_next = stationary_speed_threshold_reg;
    reverse_speed_limit_next = reverse_speed_limit_reg;
    restart_next = 1'b0;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      // latch read data and error before the access edge
      prdata_next = 32'h0000_0000;
      pslverr_next = ~addr_ok || (paddr[31:8] != 24'h00_0000) || (paddr[1:0] != 2'h0);
      if (paddr[7:0] == MSE_CTRL_OFS) begin
        prdata_next[MSE_CTRL_EN_BIT] = speed_detect_enable_reg;
        prdata_next[MSE_CTRL_STH_LSB +: 2] = stationary_speed_threshold_reg;
        prdata_next[MSE_CTRL_RTH_LSB +: 2] = reverse_speed_limit_reg;
      end else if (paddr[7:0] == MSE_STAT_OFS) begin
        prdata_next[MSE_STAT_STATE_LSB +: $bits(mse_state_e)] = state_reg;
        prdata_next[MSE_STAT_REV_BIT] = reverse_reg;
        prdata_next[MSE_STAT_VALID_BIT] = valid_reg;
      end else if (paddr[7:0] == MSE_SPD_OFS) begin
        prdata_next[MSE_SPD_W-1:0] = speed_reg;
      end else begin
        // unmapped reads as zero with an error
        prdata_next = 32'h0000_0000;
      end
    end
    if (wr_take && (paddr[7:0] == MSE_CTRL_OFS)) begin
      // control write takes effect on the access edge
      speed_detect_enable_next = pwdata[MSE_CTRL_EN_BIT];
      stationary_speed_threshold_next = pwdata[MSE_CTRL_STH_LSB +: 2];
      reverse_speed_limit_next = pwdata[MSE_CTRL_RTH_LSB +: 2];
      restart_next = pwdata[MSE_CTRL_RESTART_BIT];
    end
  end

  // register file flops
  // restart is a one-cycle strobe, cleared every cycle it is not written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_detect_enable_reg <= MSE_CTRL_EN_RST;
      stationary_speed_threshold_reg <= MSE_CTRL_STH_RST;
      reverse_speed_limit_reg <= MSE_CTRL_RTH_RST;
      restart_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      speed_detect_enable_reg <= speed_detect_enable_next;
      stationary_speed_threshold_reg <= stationary_speed_threshold_next;
      reverse_speed_limit_reg <= reverse_speed_limit_next;
      restart_reg <= restart_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // sequencer next state; one decision per cycle
  // the three hand-off states are terminal; only a wake or a restart
  // leaves them, since the rest of the start flow lives elsewhere
  always_comb begin
    state_next = state_reg;
    speed_next = speed_reg;
    reverse_next = reverse_reg;
    valid_next = valid_reg;
    detect_request_next = 1'b0;
    case (state_reg)
      MSE_POWER_ON: begin
        // nothing to wait for; go test the detection switch
        state_next = MSE_EN_CHECK;
      end
      MSE_EN_CHECK: begin
        if (speed_detect_enable_reg) begin
          state_next = MSE_SPEED_DETECT;
          detect_request_next = 1'b1;
        end else begin
          state_next = MSE_BRAKE_HANDOFF;
        end
      end
      MSE_SPEED_DETECT: begin
        // hold the request until the measurement is back
        if (detect_done) begin
          speed_next = detect_speed;
          reverse_next = detect_reverse;
          valid_next = 1'b1;
          state_next = MSE_STILL_CHECK;
        end else begin
          detect_request_next = 1'b1;
        end
      end
      MSE_STILL_CHECK: begin
        // equal speed is not below, so it goes on to direction
        if (still_if.below) begin
          state_next = MSE_BRAKE_HANDOFF;
        end else begin
          state_next = MSE_DIR_CHECK;
        end
      end
      MSE_DIR_CHECK: begin
        // forward spin resynchronises with no start-up steps
        if (!reverse_reg) begin
          state_next = MSE_CLOSED_HANDOFF;
        end else begin
          state_next = MSE_REV_CHECK;
        end
      end
      MSE_REV_CHECK: begin
        // too fast to touch: measure again and let it slow down
        if (rev_if.above) begin
          state_next = MSE_SPEED_DETECT;
          detect_request_next = 1'b1;
        end else begin
          state_next = MSE_REVEN_HANDOFF;
        end
      end
      MSE_BRAKE_HANDOFF: begin
        state_next = MSE_BRAKE_HANDOFF; // held until wake or restart
      end
      MSE_CLOSED_HANDOFF: begin
        state_next = MSE_CLOSED_HANDOFF;
      end
      MSE_REVEN_HANDOFF: begin
        state_next = MSE_REVEN_HANDOFF;
      end
      default: begin
        state_next = MSE_POWER_ON; // illegal code recovers
      end
    endcase
    // leaving low power or a software restart wins over any step
    if (wake_pulse || restart_reg) begin
      state_next = MSE_POWER_ON;
      detect_request_next = 1'b0;
    end
  end

  // sequencer flops; reset lands in power-on
  // measurement fields keep their last values across a restart so
  // software can still read what was seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MSE_POWER_ON;
      speed_reg <= '0;
      reverse_reg <= 1'b0;
      valid_reg <= 1'b0;
      detect_request_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      speed_reg <= speed_next;
      reverse_reg <= reverse_next;
      valid_reg <= valid_next;
      detect_request_reg <= detect_request_next;
    end
  end

  // outputs from flops, except pslverr gated by the access phase, hand-offs decoded from state and pready tied high
  // pready is tied high: every transfer ends after one access cycle
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg & psel & penable;
  assign detect_request = detect_request_reg;
  // hand-offs decoded by state name rather than by bit position,
  // so a change of state encoding cannot move them silently
  assign brake_enable_decision = (state_reg == MSE_BRAKE_HANDOFF);
  assign feedback_commutation_state = (state_reg == MSE_CLOSED_HANDOFF);
  assign reverse_drive_enable = (state_reg == MSE_REVEN_HANDOFF);

endmodule

// ==== bench/mse_seq_props.sv ====
// port assertions for the start sequencer
`timescale 1ns/1ns
module mse_seq_props
  import mse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_power_exit,
  input wire logic detect_request,
  input wire logic detect_done,
  input wire logic [MSE_SPD_W-1:0] detect_speed,
  input wire logic detect_reverse,
  input wire logic brake_enable_decision,
  input wire logic feedback_commutation_state,
  input wire logic reverse_drive_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a measurement accepted at this edge
  wire took = detect_request && detect_done;
  // any hand-off output up
  wire hand = brake_enable_decision | feedback_commutation_state | reverse_drive_enable;
  property p_drop; took |=> !detect_request; endproperty
  a_drop: assert property (p_drop) else $error("request held");
  // speeds chosen at or beyond every level so the route is fixed
  property p_fwd; took && !detect_reverse && detect_speed >= 8'h20
    |-> ##[3:4] feedback_commutation_state; endproperty
  a_fwd: assert property (p_fwd) else $error("no closed loop");
  property p_still; took && detect_speed < 8'h04 |-> ##[2:3] brake_enable_decision; endproperty
  a_still: assert property (p_still) else $error("no brake");
  property p_fast; took && detect_reverse && detect_speed > 8'h40
    |-> ##[4:5] detect_request; endproperty
  a_fast: assert property (p_fast) else $error("no redetect");
  property p_one; $onehot0({brake_enable_decision, feedback_commutation_state,
    reverse_drive_enable}); endproperty
  a_one: assert property (p_one) else $error("two hand-offs");
  property p_quiet; hand |-> !detect_request; endproperty
  a_quiet: assert property (p_quiet) else $error("request in hand-off");
  property p_wake; $rose(low_power_exit) |-> ##[2:4] !hand; endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  // access phase flags an error exactly for an unmapped word
  property p_err; psel && penable |-> pslverr == !(paddr == MSE_CTRL_OFS ||
    paddr == MSE_STAT_OFS || paddr == MSE_SPD_OFS); endproperty
  a_err: assert property (p_err) else $error("stray slverr");
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  c_rev: cover property (took && detect_reverse);
  c_fb: cover property ($rose(feedback_commutation_state));
  c_wake: cover property ($rose(low_power_exit));
endmodule
bind mse_seq mse_seq_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_power_exit(low_power_exit), .detect_request(detect_request),
  .detect_done(detect_done), .detect_speed(detect_speed), .detect_reverse(detect_reverse),
  .brake_enable_decision(brake_enable_decision),
  .feedback_commutation_state(feedback_commutation_state),
  .reverse_drive_enable(reverse_drive_enable)
);

// ==== bench/mse_motor.sv ====
// behavioural motor answering speed measurements
`timescale 1ns/1ns
module mse_motor
  import mse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic detect_request,
  input wire logic [MSE_SPD_W-1:0] spd,
  input wire logic rev,
  input wire logic [3:0] lag,
  output logic detect_done,
  output logic [MSE_SPD_W-1:0] detect_speed,
  output logic detect_reverse
);
  logic [3:0] cnt_reg; // cycles into a measurement
  // done pulses lag+1 cycles into a request; lines wander between answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      detect_done <= 1'b0;
      detect_speed <= 8'h00;
      detect_reverse <= 1'b0;
    end else if (detect_request && !detect_done && cnt_reg == lag) begin
      cnt_reg <= 4'h0;
      detect_done <= 1'b1;
      detect_speed <= spd;
      detect_reverse <= rev;
    end else begin
      cnt_reg <= (detect_request && !detect_done) ? cnt_reg + 4'h1 : 4'h0;
      detect_done <= 1'b0;
      detect_speed <= ~detect_speed;
      detect_reverse <= ~detect_reverse;
    end
  end
endmodule

// ==== bench/tb_motor_start_sequencer_entry.sv ====
// self-checking bench for the start sequencer entry
`timescale 1ns/1ns
module tb_motor_start_sequencer_entry;
  import mse_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power_exit = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, err, rev = 0, detect_request, detect_done, detect_reverse;
  logic brake_enable_decision, feedback_commutation_state, reverse_drive_enable;
  logic [MSE_SPD_W-1:0] detect_speed, spd = 0;
  logic [3:0] lag = 4'h1;
  int errors = 0, num_checks = 0;
  wire hand = brake_enable_decision | feedback_commutation_state | reverse_drive_enable;
  wire [31:0] ho = {29'h0, reverse_drive_enable, feedback_commutation_state,
    brake_enable_decision};
  always #20 pclk = ~pclk; // 25 MHz
  mse_seq i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_exit(low_power_exit), .detect_request(detect_request),
    .detect_done(detect_done), .detect_speed(detect_speed), .detect_reverse(detect_reverse),
    .brake_enable_decision(brake_enable_decision),
    .feedback_commutation_state(feedback_commutation_state),
    .reverse_drive_enable(reverse_drive_enable)
  );
  mse_motor i_motor (
    .pclk(pclk), .presetn(presetn), .detect_request(detect_request), .spd(spd), .rev(rev),
    .lag(lag), .detect_done(detect_done), .detect_speed(detect_speed),
    .detect_reverse(detect_reverse)
  );
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer, then an idle cycle
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    if (n >= 20) print_verdict();
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // bounded wait for the hand-off level h
  task automatic wait_hand(logic h);
    int n;
    n = 0;
    while (hand !== h && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60) errors++;
    if (n >= 60) print_verdict();
  endtask
  // restart with control c and a motor at speed s, direction r
  task automatic run(logic [7:0] c, logic [7:0] s, logic r, logic [2:0] e);
    spd <= s;
    rev <= r;
    apb(1, MSE_CTRL_OFS, {24'h0, c | 8'h20});
    repeat (3) @(posedge pclk);
    wait_hand(1);
    chk("handoff", {29'h0, e}, ho);
  endtask
  task automatic s_reset();
    wait_hand(1);
    chk("handoff", 32'h1, ho);
    apb(0, MSE_STAT_OFS, 32'h0);
    chk("status", 32'h40, rd);
    apb(0, MSE_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, rd);
    $display("reset test done");
  endtask
  task automatic s_route();
    run(8'h01, 8'h03, 0, 3'h1);
    run(8'h03, 8'h07, 0, 3'h1);
    run(8'h05, 8'h10, 0, 3'h2);
    run(8'h01, 8'h08, 1, 3'h4);
    run(8'h09, 8'h08, 1, 3'h4);
    run(8'h11, 8'h10, 1, 3'h4);
    run(8'h07, 8'h20, 0, 3'h2);
    $display("route test done");
  endtask
  task automatic s_wake();
    low_power_exit <= 1;
    repeat (3) @(posedge pclk);
    chk("wake_sync", 32'h2, ho);
    @(posedge pclk);
    chk("wake", 32'h0, ho);
    low_power_exit <= 0;
    wait_hand(1);
    chk("handoff", 32'h2, ho);
    $display("wake test done");
  endtask
  // slow reverse answers, too fast first, then at the limit
  task automatic s_rev();
    int n, k;
    n = 0;
    k = 0;
    lag <= 4'h9;
    spd <= 8'h41;
    rev <= 1;
    apb(1, MSE_CTRL_OFS, 32'h39);
    while (k < 2 && n < 200) begin
      @(posedge pclk);
      n++;
      if (detect_done === 1'b1) k++;
    end
    chk("redetect", 32'h2, k);
    spd <= 8'h40;
    wait_hand(1);
    chk("handoff", 32'h4, ho);
    apb(0, MSE_STAT_OFS, 32'h0);
    chk("status", 32'h700, rd);
    apb(0, MSE_SPD_OFS, 32'h0);
    chk("speed", 32'h40, rd);
    $display("reverse test done");
  endtask
  task automatic s_regs();
    apb(1, MSE_CTRL_OFS, 32'h3F);
    apb(0, MSE_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1F, rd);
    apb(1, MSE_STAT_OFS, 32'h0);
    wait_hand(1);
    apb(0, MSE_STAT_OFS, 32'h0);
    chk("status", 32'h700, rd);
    apb(0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    $display("register test done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    s_reset();
    s_route();
    s_wake();
    s_rev();
    s_regs();
    print_verdict();
  end
endmodule
